// ===== core/adccs_top.sv
// top of the conversion control and serial port block
`include "adccs_cfg.svh"
`default_nettype none
module adccs_top
  import adccs_pkg::*;
#(
  parameter int unsigned SCLK_TIMEOUT_CYC = `ADCCS_SCLK_LOW_TIMEOUT_CYC,
  parameter int unsigned RATE0_CYC = 781250,
  parameter int unsigned RATE1_CYC = 400000,
  parameter int unsigned RATE2_CYC = 204082,
  parameter int unsigned RATE3_CYC = 108696,
  parameter int unsigned RATE4_CYC = 62500,
  parameter int unsigned RATE5_CYC = 41667,
  parameter int unsigned RATE6_CYC = 30303,
  parameter int unsigned RATE7_CYC = 30303
)(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  output logic SERIAL_OUT_READY_N_O,
  output logic SERIAL_OUT_READY_N_OE,
  input wire logic [11:0] SAMPLE_IN,
  output logic [2:0] GAIN_SEL,
  output logic [1:0] POS_SEL,
  output logic [1:0] NEG_SEL,
  output logic NEG_GND,
  output logic CONV_ACTIVE
);
  // ----------------------------------------
  // synchronised pins
  // ----------------------------------------
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  // chip select idles high: reset the chain deselected so data out stays released
  adccs_sync3 #(.RST_VAL(1'b1)) u_sync_cs (.clk(REF_CLK), .rst_n(NRST), .din(CS_N), .dout(cs_n_s));
  adccs_sync3 u_sync_sclk (.clk(REF_CLK), .rst_n(NRST), .din(SCLK), .dout(sclk_s));
  adccs_sync3 u_sync_sdi (.clk(REF_CLK), .rst_n(NRST), .din(SDI), .dout(sdi_s));
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  adccs_conv_if cif ();
  adccs_pair_s pair;
  logic [31:0] cyc_tbl [8];
  logic [31:0] cyc_sel;
  assign cyc_tbl[0] = RATE0_CYC;
  assign cyc_tbl[1] = RATE1_CYC;
  assign cyc_tbl[2] = RATE2_CYC;
  assign cyc_tbl[3] = RATE3_CYC;
  assign cyc_tbl[4] = RATE4_CYC;
  assign cyc_tbl[5] = RATE5_CYC;
  assign cyc_tbl[6] = RATE6_CYC;
  assign cyc_tbl[7] = RATE7_CYC;
  adccs_seq u_seq (
    .clk(REF_CLK),
    .rst_n(NRST),
    .cif(cif),
    .sample_in(SAMPLE_IN),
    .gain_sel(GAIN_SEL),
    .pair_sel(pair),
    .conv_active(CONV_ACTIVE),
    .conv_cyc_sel(cyc_sel),
    .conv_cyc_tbl(cyc_tbl)
  );
  assign POS_SEL = pair.pos_sel;
  assign NEG_SEL = pair.neg_sel;
  assign NEG_GND = pair.neg_gnd;
  // ----------------------------------------
  // serial port state
  // ----------------------------------------
  logic sclk_d_ff;
  logic cs_d_ff;
  logic [31:0] low_cnt_ff;
  logic [4:0] bit_cnt_ff;
  adccs_word_t rx_ff;
  adccs_word_t tx_ff;
  logic out_ff;
  logic ready_ff;
  logic load_ff;
  adccs_word_t cfg_out_ff;
  // edge and event decode
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire cs_fall = ~cs_n_s & cs_d_ff;
  // timeout ends on the first high clock, so that rising edge still shifts a bit
  wire timeout = ~sclk_s & (low_cnt_ff >= SCLK_TIMEOUT_CYC);
  wire port_reset = cs_n_s | timeout;
  wire word_end = sclk_fall & (bit_cnt_ff == 5'd15);
  wire first_bit = (bit_cnt_ff == 5'd0);
  wire [15:0] rx_next = {rx_ff[14:0], sdi_s};
  assign cif.cfg_load = load_ff;
  assign cif.cfg_word = cfg_out_ff;
  // ----------------------------------------
  // clock-low watchdog
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      low_cnt_ff <= 32'h0000_0000;
    end else if (sclk_s) begin
      low_cnt_ff <= 32'h0000_0000;
    end else if (!timeout) begin
      low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
    end
  end
  // ----------------------------------------
  // edge history
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_n_s;
    end
  end
  // ----------------------------------------
  // receive shifter, falling edge sample
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      bit_cnt_ff <= 5'd0;
      rx_ff <= 16'h0000;
      load_ff <= 1'b0;
      cfg_out_ff <= 16'h0000;
    end else begin
      load_ff <= 1'b0;
      if (port_reset) begin
        bit_cnt_ff <= 5'd0;
      end else if (sclk_fall) begin
        rx_ff <= rx_next;
        if (word_end) begin
          bit_cnt_ff <= 5'd0;
          load_ff <= 1'b1;
          cfg_out_ff <= rx_next;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 5'd1;
        end
      end
    end
  end
  // ----------------------------------------
  // transmit shifter and ready flag
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_ff <= 16'h0000;
      out_ff <= 1'b1;
      ready_ff <= 1'b0;
    end else begin
      // new result wins over a clear in the same cycle
      if (cif.result_new) begin
        ready_ff <= 1'b1;
      end else if (sclk_rise && first_bit && !port_reset) begin
        ready_ff <= 1'b0;
      end
      if (port_reset || cs_fall) begin
        tx_ff <= cif.result;
        out_ff <= ~(ready_ff | cif.result_new);
      end else if (sclk_rise) begin
        out_ff <= tx_ff[15];
        tx_ff <= {tx_ff[14:0], 1'b0};
      end else if (first_bit && !sclk_s && !sclk_fall) begin
        // ready shown only between words; first data bit holds until next rise
        out_ff <= ~(ready_ff | cif.result_new);
      end
    end
  end
  assign SERIAL_OUT_READY_N_O = out_ff;
  assign SERIAL_OUT_READY_N_OE = ~cs_n_s;
endmodule
`default_nettype wire

// ===== common/adccs_cfg.svh
// constants for the conversion control and serial port block
`ifndef ADCCS_CFG_SVH
`define ADCCS_CFG_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define ADCCS_CLK_PERIOD_NS 10
`define ADCCS_SCLK_LOW_TIMEOUT_MS 28
`define ADCCS_SCLK_LOW_TIMEOUT_CYC ((`ADCCS_SCLK_LOW_TIMEOUT_MS * 1000000) / `ADCCS_CLK_PERIOD_NS)
// ----------------------------------------
// configuration word fields
// ----------------------------------------
`define ADCCS_CFG_START_BIT 15
`define ADCCS_CFG_MUX_HI 14
`define ADCCS_CFG_MUX_LO 12
`define ADCCS_CFG_GAIN_HI 11
`define ADCCS_CFG_GAIN_LO 9
`define ADCCS_CFG_MODE_BIT 8
`define ADCCS_CFG_RATE_HI 7
`define ADCCS_CFG_RATE_LO 5
`define ADCCS_CFG_RESET 16'h058B
// ----------------------------------------
// serial word
// ----------------------------------------
`define ADCCS_WORD_BITS 16
`endif

// ===== common/adccs_pkg.sv
// types for the conversion control and serial port block
`default_nettype none
package adccs_pkg;
  // conversion sequencer states, gray along idle-run-done
  typedef enum logic [1:0] {
    ADCCS_IDLE = 2'b00,
    ADCCS_RUN = 2'b01,
    ADCCS_DONE = 2'b11
  } adccs_state_e;
  // converter input pairing
  typedef struct packed {
    logic [1:0] pos_sel;
    logic [1:0] neg_sel;
    logic neg_gnd;
  } adccs_pair_s;
  typedef logic [15:0] adccs_word_t;
endpackage
`default_nettype wire

// ===== common/adccs_conv_if.sv
// link between the sequencer and the serial port
`default_nettype none
interface adccs_conv_if;
  import adccs_pkg::*;
  logic cfg_load;
  adccs_word_t cfg_word;
  adccs_word_t result;
  logic result_new;
  modport seq (input cfg_load, input cfg_word, output result, output result_new);
  modport port (output cfg_load, output cfg_word, input result, input result_new);
endinterface
`default_nettype wire

// ===== core/adccs_sync3.sv
// three-stage input synchroniser with agreement filter
`default_nettype none
module adccs_sync3 #(
  parameter logic RST_VAL = 1'b0 // idle level of the pin, so reset shows no false edge
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // ----------------------------------------
  // stages
  // ----------------------------------------
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;
  // shift chain; output follows when stage two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        q_ff <= s3_ff;
      end
    end
  end
  assign dout = q_ff;
endmodule
`default_nettype wire

// ===== core/adccs_seq.sv
// conversion sequencer: modes, timing and result register
`include "adccs_cfg.svh"
`default_nettype none
module adccs_seq
  import adccs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  adccs_conv_if.seq cif,
  input wire logic [11:0] sample_in,
  output logic [2:0] gain_sel,
  output adccs_pair_s pair_sel,
  output logic conv_active,
  output logic [31:0] conv_cyc_sel,
  input wire logic [31:0] conv_cyc_tbl [8]
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  adccs_state_e state_ff;
  adccs_state_e nxt_state;
  adccs_word_t cfg_ff;
  logic [31:0] cnt_ff;
  adccs_word_t res_ff;
  logic new_ff;
  // decoded fields
  wire mode_single = cfg_ff[`ADCCS_CFG_MODE_BIT];
  wire [2:0] mux_f = cfg_ff[`ADCCS_CFG_MUX_HI:`ADCCS_CFG_MUX_LO];
  // a word arriving now sets the length of the conversion it starts
  wire [2:0] rate_f = cif.cfg_load ? cif.cfg_word[`ADCCS_CFG_RATE_HI:`ADCCS_CFG_RATE_LO] :
    cfg_ff[`ADCCS_CFG_RATE_HI:`ADCCS_CFG_RATE_LO];
  wire start_req = cif.cfg_load & cif.cfg_word[`ADCCS_CFG_START_BIT];
  wire new_single = cif.cfg_word[`ADCCS_CFG_MODE_BIT];
  wire cnt_end = (cnt_ff == 32'h0000_0000);
  assign gain_sel = cfg_ff[`ADCCS_CFG_GAIN_HI:`ADCCS_CFG_GAIN_LO];
  assign conv_cyc_sel = conv_cyc_tbl[rate_f];
  assign conv_active = (state_ff == ADCCS_RUN);
  assign cif.result = res_ff;
  assign cif.result_new = new_ff;
  // ----------------------------------------
  // input pair decode
  // ----------------------------------------
  always_comb begin
    pair_sel = '{pos_sel: 2'd0, neg_sel: 2'd1, neg_gnd: 1'b0};
    case (mux_f)
      3'd0: pair_sel = '{2'd0, 2'd1, 1'b0};
      3'd1: pair_sel = '{2'd0, 2'd3, 1'b0};
      3'd2: pair_sel = '{2'd1, 2'd3, 1'b0};
      3'd3: pair_sel = '{2'd2, 2'd3, 1'b0};
      3'd4: pair_sel = '{2'd0, 2'd0, 1'b1};
      3'd5: pair_sel = '{2'd1, 2'd0, 1'b1};
      3'd6: pair_sel = '{2'd2, 2'd0, 1'b1};
      default: pair_sel = '{2'd3, 2'd0, 1'b1};
    endcase
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADCCS_IDLE: begin
        // single shot on request, continuous starts on its own
        if (cif.cfg_load && (start_req || !new_single)) begin
          nxt_state = ADCCS_RUN;
        end
      end
      ADCCS_RUN: begin
        if (cnt_end) begin
          nxt_state = ADCCS_DONE;
        end
      end
      ADCCS_DONE: begin
        if (!mode_single) begin
          nxt_state = ADCCS_RUN;
        end else begin
          nxt_state = ADCCS_IDLE;
        end
      end
      default: nxt_state = ADCCS_IDLE;
    endcase
  end
  // ----------------------------------------
  // registers; power-up idle with defaults
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ADCCS_IDLE;
      cfg_ff <= `ADCCS_CFG_RESET;
      cnt_ff <= 32'h0000_0000;
      res_ff <= 16'h0000;
      new_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (cif.cfg_load) begin
        cfg_ff <= cif.cfg_word;
      end
      // conversion length follows the rate field
      if (nxt_state == ADCCS_RUN && state_ff != ADCCS_RUN) begin
        cnt_ff <= conv_cyc_sel;
      end else if (!cnt_end) begin
        cnt_ff <= cnt_ff - 32'h0000_0001;
      end
      // result left-justified, low nibble zero
      if (state_ff == ADCCS_RUN && cnt_end) begin
        res_ff <= {sample_in, 4'h0};
      end
      new_ff <= (state_ff == ADCCS_RUN) && cnt_end;
    end
  end
endmodule
`default_nettype wire

// ===== sim/adccs_chk.sv
// pin-level assertions for the conversion control block
`include "adccs_cfg.svh"
`default_nettype none
module adccs_chk #(
  parameter int unsigned TMO_CYC = `ADCCS_SCLK_LOW_TIMEOUT_CYC
)(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SDI,
  input wire logic SERIAL_OUT_READY_N_O,
  input wire logic SERIAL_OUT_READY_N_OE,
  input wire logic [11:0] SAMPLE_IN,
  input wire logic [2:0] GAIN_SEL,
  input wire logic [1:0] POS_SEL,
  input wire logic [1:0] NEG_SEL,
  input wire logic NEG_GND,
  input wire logic CONV_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic seen_sclk_ff; // high once the host has clocked the port
  logic [31:0] low_run_ff; // samples since the serial clock last stood high
  // idle and selected, well before the clock-low timeout may reset the port
  wire idle_quiet = !SCLK && !CS_N && !CONV_ACTIVE && (low_run_ff < TMO_CYC);
  // count the low run of the serial clock, saturating
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      low_run_ff <= 32'h0000_0000;
    end else if (SCLK) begin
      low_run_ff <= 32'h0000_0000;
    end else if (low_run_ff != 32'hFFFF_FFFF) begin
      low_run_ff <= low_run_ff + 32'h0000_0001;
    end
  end
  // remember the first serial clock pulse after reset
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      seen_sclk_ff <= 1'b0;
    end else if (SCLK) begin
      seen_sclk_ff <= 1'b1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  cs_high_hiz_a: assert property (CS_N [*6] |-> !SERIAL_OUT_READY_N_OE)
    else $error("data out driven while deselected");
  cs_low_drive_a: assert property (!CS_N [*6] |-> SERIAL_OUT_READY_N_OE)
    else $error("data out idle while selected");
  cfg_hold_a: assert property (!SCLK [*8] |=> $stable({GAIN_SEL, POS_SEL, NEG_GND}))
    else $error("config fields moved without clocks");
  pair_legal_a: assert property (NEG_GND || (NEG_SEL == 2'd3 && POS_SEL != 2'd3) ||
    (NEG_SEL == 2'd1 && POS_SEL == 2'd0)) else $error("illegal input pairing");
  idle_start_a: assert property (!seen_sclk_ff |-> !CONV_ACTIVE)
    else $error("conversion before any request");
  ready_shown_a: assert property (!SCLK [*8] ##0 ($fell(CONV_ACTIVE) && !CS_N) |-> ##[1:4] !SERIAL_OUT_READY_N_O)
    else $error("ready not shown after conversion");
  out_steady_a: assert property (idle_quiet [*8] |=> $stable(SERIAL_OUT_READY_N_O))
    else $error("data out moved without clock rise");
  shot_parked_a: assert property ((CS_N && !CONV_ACTIVE) [*3] |=> !CONV_ACTIVE)
    else $error("conversion started while parked");
  cover property ($fell(CONV_ACTIVE));
  cover property ($rose(SERIAL_OUT_READY_N_OE));
  cover property (!SCLK [*8] ##1 $changed(GAIN_SEL));
endmodule
bind adccs_top adccs_chk #(.TMO_CYC(SCLK_TIMEOUT_CYC)) u_chk (.*);
`default_nettype wire

// ===== sim/adccs_host.sv
// serial host model that drives the port msb first
`default_nettype none
module adccs_host (
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic cs_tied
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // shift n bits; a short count leaves the word unfinished
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    #201; // keeps every link edge clear of the block's sampling edge
    for (int i = 15; i > 15 - n; i--) begin
      sclk = 1'b1;
      sdi = w[i];
      #62.5;
      rd[i] = sdo;
      sclk = 1'b0;
      #62.5;
    end
    sdi = ~sdi; // released line must not look held
    #150;
    cs_n = cs_tied;
    #250;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the conversion control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO_CYC = 200;
  localparam int RATE0 = 60;
  localparam int RATE1 = 80;
  localparam int RATE2 = 100;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_tied = 1'b1;
  logic [11:0] sample = 12'h000;
  logic [15:0] rd;
  wire logic cs_n, sclk, sdi, sdo, sdo_o, sdo_oe, gnd, active;
  wire logic [2:0] gain;
  wire logic [1:0] pos, neg;
  int failures = 0;
  int samples_checked = 0;
  int act_cyc = 0;
  assign sdo = sdo_oe ? sdo_o : 1'b0; // pull-down load
  always #5 ref_clk = ~ref_clk;
  // cycles spent converting
  always @(posedge ref_clk) if (active === 1'b1) act_cyc++;
  adccs_top #(.SCLK_TIMEOUT_CYC(TMO_CYC), .RATE0_CYC(RATE0), .RATE1_CYC(RATE1), .RATE2_CYC(RATE2),
    .RATE3_CYC(120), .RATE4_CYC(140), .RATE5_CYC(160), .RATE6_CYC(180), .RATE7_CYC(200)) u_dut (
    .REF_CLK(ref_clk), .NRST(nrst), .CS_N(cs_n), .SCLK(sclk), .SDI(sdi),
    .SERIAL_OUT_READY_N_O(sdo_o), .SERIAL_OUT_READY_N_OE(sdo_oe), .SAMPLE_IN(sample),
    .GAIN_SEL(gain), .POS_SEL(pos), .NEG_SEL(neg), .NEG_GND(gnd), .CONV_ACTIVE(active));
  adccs_host u_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .cs_tied(cs_tied));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one whole word, then back onto the falling clock edge
  task automatic send(input logic [15:0] w);
    u_host.xfer(w, 16, rd);
    @(negedge ref_clk);
  endtask
  task automatic t_mux();
    logic [2:0] p;
    logic [15:0] e;
    for (int i = 0; i < 8; i++) begin
      p = i[2:0];
      send({1'b0, p, p, 1'b1, 8'h0B});
      check("gain", {13'h0, gain}, {13'h0, p});
      e = {13'h0, (i < 4) ? ((i == 0) ? 2'd0 : p[1:0] - 2'd1) : p[1:0], p[2]};
      check("pos gnd", {13'h0, pos, gnd}, e);
      if (i < 4) check("neg", {14'h0, neg}, {14'h0, (i == 0) ? 2'd1 : 2'd3});
    end
  endtask
  task automatic t_timeout();
    cs_tied = 1'b0;
    u_host.xfer(16'hFFFF, 5, rd);
    repeat (TMO_CYC + 20) @(negedge ref_clk);
    send({1'b0, 3'd5, 3'd6, 1'b1, 8'h0B});
    check("after idle", {12'h0, gain, pos[0]}, {12'h0, 3'd6, 1'b1});
  endtask
  task automatic t_single();
    int n;
    sample = 12'hA5C;
    act_cyc = 0;
    send({1'b1, 3'd0, 3'd2, 1'b1, 3'd1, 5'h0B});
    n = 0;
    while (active !== 1'b0 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(negedge ref_clk);
    check("ready", {15'h0, sdo}, 16'h0);
    check("conv length", act_cyc[15:0], 16'(RATE1 + 1));
    sample = 12'h3C1;
    repeat (300) @(negedge ref_clk);
    check("parked", {15'h0, active}, 16'h0);
    send({1'b0, 3'd0, 3'd2, 1'b1, 3'd1, 5'h0B});
    check("result", rd, {12'hA5C, 4'h0});
  endtask
  task automatic t_cont();
    sample = 12'h2B4;
    send({1'b0, 3'd0, 3'd2, 1'b0, 3'd2, 5'h0B});
    act_cyc = 0;
    repeat (400) @(negedge ref_clk);
    check("running", {15'h0, act_cyc > 380}, 16'h1);
    sample = 12'h7E2;
    repeat (RATE2 + 20) @(negedge ref_clk);
    send({1'b0, 3'd0, 3'd2, 1'b1, 3'd2, 5'h0B});
    check("latest", rd, {12'h7E2, 4'h0});
    repeat (2 * RATE2) @(negedge ref_clk);
    check("stopped", {15'h0, active}, 16'h0);
  endtask
  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (10) @(negedge ref_clk);
    check("reset pins", {5'h0, sdo_oe, sdo_o, active, gain, pos, neg, gnd}, 16'h0242);
    t_mux();
    t_timeout();
    t_single();
    t_cont();
    end_of_test();
  end
  // watchdog
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
